// *** cfrwp_assertions.sv ***
module cfrwp_checker
   import cfrwp_pkg::*;
(
   input logic        clk,
   input logic        rst,
   input logic        psel,
   input logic        penable,
   input logic        pwrite,
   input logic        opValid,
   input cfrwp_op_t   opCode,
   input logic        opWord,
   input logic [15:0] opA,
   input logic [15:0] opB,
   input logic [3:0]  workReg,
   input logic [7:0]  directAddr,
   input logic [15:0] resultOut,
   input logic [7:0]  statusFlags,
   input logic [7:0]  windowPtrLow,
   input logic [7:0]  windowPtrHigh,
   input logic [7:0]  workAddr,
   input logic        directAllowed,
   input logic [2:0]  stackDepth
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****************
   // flag and window checks
   // ****************
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic apbWr;
   assign apbWr = psel && penable && pwrite;

   function automatic logic [7:0] mapAddr(logic [7:0] lo, logic [7:0] hi, logic [3:0] r);
      if (!lo[2])
         return {lo[7:4], r};
      return r[3] ? {hi[7:3], r[2:0]} : {lo[7:3], r[2:0]};
   endfunction

   // a bus write in the same cycle may legally change other bits, so it is excluded
   sequence s_irq;
      opValid && opCode == OP_IRQ && stackDepth < 3'h7 && !apbWr;
   endsequence
   sequence s_iret;
      opValid && opCode == OP_IRET && !apbWr;
   endsequence

   a_nest_restore: assert property (s_irq ##1 s_iret |=> statusFlags == $past(statusFlags, 2))
      else $error("status not restored on return");
   a_push_depth: assert property (s_irq |=> stackDepth == $past(stackDepth) + 3'h1)
      else $error("stack depth not advanced on entry");
   a_add_carry: assert property (opValid && opCode == OP_ADD && !opWord |=>
      statusFlags[7] == (({1'h0, $past(opA[7:0])} + $past(opB[7:0])) > 9'h0ff))
      else $error("byte add carry wrong");
   a_carry_set: assert property (opValid && opCode == OP_SCF && !apbWr |=>
      statusFlags == ($past(statusFlags) | 8'h80))
      else $error("set carry disturbed status");
   a_carry_flip: assert property (opValid && opCode == OP_CCF && !apbWr |=>
      statusFlags == ($past(statusFlags) ^ 8'h80))
      else $error("toggle carry wrong");
   a_sign_zero: assert property (opValid && opCode == OP_AND && !opWord |=>
      statusFlags[6] == (resultOut[7:0] == 8'h00) && statusFlags[5] == resultOut[7]
      && resultOut[7:0] == ($past(opA[7:0]) & $past(opB[7:0])))
      else $error("zero or sign flag wrong");
   a_fixed_zero: assert property (statusFlags[1] == 1'h0 && windowPtrLow[1:0] == 2'h0
      && windowPtrHigh[1:0] == 2'h0)
      else $error("reserved bits not zero");
   a_single_ptr: assert property (opValid && opCode == OP_SRP |=>
      windowPtrLow[7:2] == {$past(opA[4:0]), 1'h0} && !windowPtrHigh[2])
      else $error("single window pointer wrong");
   a_work_map: assert property (1'h1 |=>
      workAddr == mapAddr($past(windowPtrLow), $past(windowPtrHigh), $past(workReg)))
      else $error("working register mapped wrong");
   a_direct_grp: assert property (1'h1 |=>
      directAllowed == ($past(directAddr[7:4]) != 4'hd))
      else $error("direct access check wrong");
   a_space_set: assert property (opValid && opCode == OP_SDM |=> statusFlags[0])
      else $error("data space bit not set");
endmodule

// *** cfrwp_flag_stack.sv ***
`include "cfrwp_map.svh"
module cfrwp_flag_stack
(
   input  logic       clk,
   input  logic       rst,
   input  logic       push,
   input  logic       pop,
   input  logic [7:0] pushData,
   output logic [7:0] topData,
   output logic [2:0] depth,
   output logic       overflow
);
   logic [7:0] slots [0:`CFRWP_STACK_DEPTH-1];
   logic       full;
   logic       empty;

   assign full = (depth == 3'(`CFRWP_STACK_DEPTH));
   assign empty = (depth == 3'h0);
   // an empty stack answers zero rather than a stale slot
   assign topData = empty ? 8'h00 : slots[depth - 3'h1];

   always_ff @(posedge clk)
   begin
      if (push && !full)
      begin
         slots[depth] <= pushData;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         depth <= 3'h0;
      end
      else if (push && !full)
      begin
         depth <= depth + 3'h1;
      end
      else if (pop && !empty)
      begin
         depth <= depth - 3'h1;
      end
   end

   // an eighth nested entry is dropped, so the flag stays until reset
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         overflow <= 1'b0;
      end
      else if (push && full)
      begin
         overflow <= 1'b1;
      end
   end
endmodule

// *** cfrwp_map.svh ***
`ifndef CFRWP_MAP_SVH
`define CFRWP_MAP_SVH
`define CFRWP_IDX_FLAGS    8'he7
`define CFRWP_IDX_PTR_LOW  8'he8
`define CFRWP_IDX_PTR_HIGH 8'he9
`define CFRWP_IDX_STACK    8'h00
`define CFRWP_BIT_C        7
`define CFRWP_BIT_Z        6
`define CFRWP_BIT_S        5
`define CFRWP_BIT_V        4
`define CFRWP_BIT_DA       3
`define CFRWP_BIT_H        2
`define CFRWP_BIT_RSV      1
`define CFRWP_BIT_DP       0
`define CFRWP_FLAGS_RESET  8'h00
`define CFRWP_FLAGS_WMASK  8'hfd
`define CFRWP_PTR_RESET    8'h00
`define CFRWP_PTR_MASK     8'hfc
`define CFRWP_BIT_TWIN     2
`define CFRWP_STACK_DEPTH  7
`define CFRWP_GROUPD_LO    8'hd0
`define CFRWP_GROUPD_HI    8'hdf
`endif

// *** cfrwp_pkg.sv ***
package cfrwp_pkg;
   typedef enum logic [4:0] {
      OP_NONE = 5'h00, OP_ADD = 5'h01, OP_ADC = 5'h02, OP_SUB = 5'h03,
      OP_SBC  = 5'h04, OP_CP  = 5'h05, OP_AND = 5'h06, OP_OR  = 5'h07,
      OP_XOR  = 5'h08, OP_CPL = 5'h09, OP_INC = 5'h0a, OP_DEC = 5'h0b,
      OP_TM   = 5'h0c, OP_SRA = 5'h0d, OP_SLA = 5'h0e, OP_RRC = 5'h0f,
      OP_RLC  = 5'h10, OP_ROR = 5'h11, OP_ROL = 5'h12, OP_SWAP = 5'h13,
      OP_DA   = 5'h14, OP_MULDIV = 5'h15, OP_SCF = 5'h16, OP_RCF = 5'h17,
      OP_CCF  = 5'h18, OP_SDM = 5'h19, OP_SPM = 5'h1a, OP_SRP = 5'h1b,
      OP_SET_LOWER_WINDOW_OP = 5'h1c, OP_SET_UPPER_WINDOW_OP = 5'h1d, OP_IRQ = 5'h1e, OP_IRET = 5'h1f
   } cfrwp_op_t;
endpackage

// *** cfrwp_tb.sv ***
module tb
   import cfrwp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // ****************
   // stimulus and checking
   // ****************
   logic        clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic        opValid = 1'h0, opWord = 1'h0, pready, pslverr, e;
   logic        directAllowed, dataSpace, stackOverflow;
   logic [9:0]  paddr = 10'h000;
   logic [31:0] pwdata = 32'h0, prdata, r;
   cfrwp_op_t   opCode = OP_NONE;
   logic [15:0] opA = 16'h0, opB = 16'h0, resultOut, extResult = 16'h0;
   logic [3:0]  workReg = 4'h0, extFlags = 4'h0;
   logic [7:0]  directAddr = 8'h0, statusFlags, windowPtrLow, windowPtrHigh, workAddr;
   logic [2:0]  stackDepth;
   int          mismatches = 0, checkCount = 0, cycles = 0;

   cfrwp_top u_dut (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .opValid(opValid), .opCode(opCode), .opWord(opWord), .opA(opA), .opB(opB),
      .extFlags(extFlags), .extResult(extResult), .workReg(workReg), .directAddr(directAddr),
      .resultOut(resultOut), .statusFlags(statusFlags), .windowPtrLow(windowPtrLow),
      .windowPtrHigh(windowPtrHigh), .workAddr(workAddr), .directAllowed(directAllowed),
      .dataSpace(dataSpace), .stackDepth(stackDepth), .stackOverflow(stackOverflow));

   always #50 clk = ~clk;

   // the whole run needs well under a thousand cycles
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         mismatches++;
         results();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checkCount++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      do
         @(posedge clk);
      while (pready !== 1'h1);
      r = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic go(input cfrwp_op_t c, input logic w, input logic [15:0] a,
                     input logic [15:0] b);
      @(posedge clk);
      opValid <= 1'h1;
      opCode <= c;
      opWord <= w;
      opA <= a;
      opB <= b;
      @(posedge clk);
      opValid <= 1'h0;
      @(negedge clk);
   endtask

   task automatic setIn(input logic [3:0] w, input logic [7:0] d);
      @(posedge clk);
      workReg <= w;
      directAddr <= d;
      @(posedge clk);
      @(negedge clk);
   endtask

   task automatic tRegs;
      apb(1'h0, 10'h39c, 32'h0);
      chk(r, 32'h0);
      apb(1'h0, 10'h3a0, 32'h0);
      chk(r[1:0], 2'h0);
      apb(1'h0, 10'h3fc, 32'h0);
      chk(e, 1'h1);
      apb(1'h1, 10'h39c, 32'hff);
      apb(1'h0, 10'h39c, 32'h0);
      chk(r, 32'hfd);
      // the low pointer drops its two reserved bits on a bus write
      apb(1'h1, 10'h3a0, 32'hff);
      apb(1'h0, 10'h3a0, 32'h0);
      chk(r, 32'hfc);
      chk(pready, 1'h1);
      apb(1'h1, 10'h39c, 32'h01);
      $display("test registers done");
   endtask

   function automatic logic [7:0] arith(logic s, logic [7:0] a, logic [7:0] b, logic dp);
      logic [8:0] q;
      logic       v;
      logic       h;
      q = s ? {1'h0, a} - b : {1'h0, a} + b;
      v = (s ? a[7] != b[7] : a[7] == b[7]) && q[7] != a[7];
      h = s ? a[3:0] < b[3:0] : ({1'h0, a[3:0]} + b[3:0]) > 5'h0f;
      return {q[8], q[7:0] == 8'h00, q[7], v, s, h, 1'h0, dp};
   endfunction

   task automatic tArith;
      cfrwp_op_t  c[5] = '{OP_ADD, OP_ADD, OP_ADD, OP_SUB, OP_CP};
      logic [7:0] a[5] = '{8'h0f, 8'h7f, 8'hff, 8'h00, 8'h80};
      logic [7:0] x;
      // one op of each remaining kind except AND, which tCarry covers; the carry runs on from op to op
      cfrwp_op_t  o[16] = '{OP_SLA, OP_SBC, OP_ADC, OP_RRC, OP_RLC, OP_SRA, OP_ROL, OP_OR,
                            OP_XOR, OP_CPL, OP_TM, OP_INC, OP_DEC, OP_SWAP, OP_ROR, OP_MULDIV};
      logic [7:0] p[16] = '{8'h81, 8'h01, 8'h7e, 8'h01, 8'h40, 8'h80, 8'h80, 8'h80,
                            8'h01, 8'h7f, 8'h02, 8'hff, 8'h80, 8'h12, 8'h01, 8'h00};
      logic [3:0] n[16] = '{4'h9, 4'ha, 4'h3, 4'hc, 4'h3, 4'h2, 4'h9, 4'ha,
                            4'hc, 4'ha, 4'hc, 4'hc, 4'h9, 4'h0, 4'hb, 4'hb};
      for (int i = 0; i < 5; i++)
      begin
         x = arith(c[i] != OP_ADD, a[i], 8'h01, statusFlags[0]);
         go(c[i], 1'h0, {8'h00, a[i]}, 16'h0001);
         chk(statusFlags, x);
      end
      go(OP_ADD, 1'h1, 16'hffff, 16'h0001);
      chk(statusFlags[7:4], 4'hc);
      go(OP_ADD, 1'h1, 16'h7fff, 16'h0001);
      chk(statusFlags[7:4], 4'h3);
      go(OP_ADD, 1'h0, 16'h0015, 16'h0027);
      go(OP_DA, 1'h0, 16'h003c, 16'h0000);
      chk(resultOut, 16'h0042);
      go(OP_SUB, 1'h0, 16'h0042, 16'h0015);
      go(OP_DA, 1'h0, 16'h002d, 16'h0000);
      chk(resultOut, 16'h0027);
      @(posedge clk);
      extFlags <= 4'h9;
      extResult <= 16'h8000;
      for (int i = 0; i < 16; i++)
      begin
         go(o[i], i == 15, {8'h00, p[i]}, 16'h0001);
         chk(statusFlags[7:4], n[i]);
      end
      $display("test arithmetic done");
   endtask

   task automatic tCarry;
      logic [7:0] f;
      f = statusFlags;
      go(OP_SCF, 1'h0, 16'h0, 16'h0);
      chk(statusFlags, f | 8'h80);
      go(OP_RCF, 1'h0, 16'h0, 16'h0);
      chk(statusFlags, f & 8'h7f);
      go(OP_CCF, 1'h0, 16'h0, 16'h0);
      chk(statusFlags, f | 8'h80);
      go(OP_AND, 1'h0, 16'h00f0, 16'h000f);
      chk(statusFlags[7:4], 4'hc);
      go(OP_SPM, 1'h0, 16'h0, 16'h0);
      @(negedge clk);
      chk({statusFlags[0], dataSpace}, 2'h0);
      go(OP_SDM, 1'h0, 16'h0, 16'h0);
      @(negedge clk);
      chk({statusFlags[0], dataSpace}, 2'h3);
      $display("test carry and space done");
   endtask

   task automatic tStack;
      for (int i = 0; i < 3; i++)
      begin
         apb(1'h1, 10'h39c, 32'h01 | (32'h80 >> i));
         go(OP_IRQ, 1'h0, 16'h0, 16'h0);
      end
      apb(1'h1, 10'h39c, 32'h00);
      for (int i = 0; i < 3; i++)
      begin
         go(OP_IRET, 1'h0, 16'h0, 16'h0);
         chk(statusFlags, 8'h01 | (8'h20 << i));
      end
      @(posedge clk);
      opValid <= 1'h1;
      opCode <= OP_IRQ;
      @(posedge clk);
      opCode <= OP_IRET;
      go(OP_NONE, 1'h0, 16'h0, 16'h0);
      chk({stackDepth, statusFlags}, 11'h081);
      for (int i = 0; i < 8; i++)
         go(OP_IRQ, 1'h0, 16'h0, 16'h0);
      apb(1'h0, 10'h000, 32'h0);
      chk(r, 32'h87);
      chk(stackOverflow, 1'h1);
      $display("test stack done");
   endtask

   task automatic tWindow;
      logic [7:0] d[4] = '{8'hd0, 8'hdf, 8'he7, 8'hcf};
      setIn(4'h5, 8'h00);
      go(OP_SRP, 1'h0, 16'h0003, 16'h0);
      @(negedge clk);
      chk({windowPtrLow, windowPtrHigh[2]}, 9'h030);
      chk(workAddr, 8'h15);
      go(OP_SET_LOWER_WINDOW_OP, 1'h0, 16'h0004, 16'h0);
      go(OP_SET_UPPER_WINDOW_OP, 1'h0, 16'h0009, 16'h0);
      chk({windowPtrLow, windowPtrHigh}, 16'h244c);
      setIn(4'h3, 8'h00);
      chk(workAddr, 8'h23);
      setIn(4'hd, 8'h00);
      chk(workAddr, 8'h4d);
      for (int i = 0; i < 4; i++)
      begin
         setIn(4'h0, d[i]);
         chk(directAllowed, d[i][7:4] != 4'hd);
      end
      $display("test window done");
   endtask

   task automatic results;
      $display("checks %0d mismatches %0d", checkCount, mismatches);
      if (mismatches == 0 && checkCount > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial
   begin
      repeat (4) @(posedge clk);
      rst <= 1'h0;
      @(posedge clk);
      tRegs();
      tArith();
      tCarry();
      tStack();
      tWindow();
      results();
   end
endmodule

bind cfrwp_top cfrwp_checker u_chk (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .opValid(opValid), .opCode(opCode), .opWord(opWord), .opA(opA),
   .opB(opB), .workReg(workReg), .directAddr(directAddr), .resultOut(resultOut),
   .statusFlags(statusFlags), .windowPtrLow(windowPtrLow), .windowPtrHigh(windowPtrHigh),
   .workAddr(workAddr), .directAllowed(directAllowed), .stackDepth(stackDepth));

// *** cfrwp_top.sv ***
`include "cfrwp_map.svh"
module cfrwp_top
   import cfrwp_pkg::*;
(
   input  logic        clk,
   input  logic        rst,
   input  logic [9:0]  paddr,
   input  logic        psel,
   input  logic        penable,
   input  logic        pwrite,
   input  logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic        pready,
   output logic        pslverr,
   input  logic        opValid,
   input  cfrwp_op_t   opCode,
   input  logic        opWord,
   input  logic [15:0] opA,
   input  logic [15:0] opB,
   input  logic [3:0]  extFlags,
   input  logic [15:0] extResult,
   input  logic [3:0]  workReg,
   input  logic [7:0]  directAddr,
   output logic [15:0] resultOut,
   output logic [7:0]  statusFlags,
   output logic [7:0]  windowPtrLow,
   output logic [7:0]  windowPtrHigh,
   output logic [7:0]  workAddr,
   output logic        directAllowed,
   output logic        dataSpace,
   output logic [2:0]  stackDepth,
   output logic        stackOverflow
);
   // ****************************************
   // helpers
   // ****************************************
   function automatic logic msbOf(input logic [15:0] x, input logic w);
      return w ? x[15] : x[7];
   endfunction

   function automatic logic carryOf(input logic [16:0] s, input logic w);
      return w ? s[16] : s[8];
   endfunction

   function automatic logic [15:0] fitW(input logic [15:0] x, input logic w);
      return w ? x : {8'h00, x[7:0]};
   endfunction

   // ****************************************
   // declarations
   // ****************************************
   logic [7:0]  flags;
   logic [7:0]  next_flags;
   logic [7:0]  next_ptrLow;
   logic [7:0]  next_ptrHigh;
   logic [7:0]  stackTop;
   logic [7:0]  mapAddr;
   logic [7:0]  regIndex;
   logic        aligned;
   logic        hitFlags;
   logic        hitLow;
   logic        hitHigh;
   logic        hitStack;
   logic        mapped;
   logic        busWrite;
   logic        setupRead;
   logic [15:0] aa;
   logic [15:0] bb;
   logic [16:0] sum;
   logic [15:0] aluRes;
   logic [7:0]  adj;
   logic        aluC;
   logic        aluV;
   logic        aluH;
   logic        aluKind;
   logic        updC;
   logic        updZsv;
   logic        updBcd;
   logic        cin;
   logic        daLow;
   logic        daHigh;
   logic        doPush;
   logic        doPop;

   assign statusFlags = flags;
   assign cin = flags[`CFRWP_BIT_C];

   // ****************************************
   // apb decode
   // ****************************************
   assign regIndex = paddr[9:2];
   assign aligned = (paddr[1:0] == 2'h0);
   assign hitFlags = aligned && (regIndex == `CFRWP_IDX_FLAGS);
   assign hitLow = aligned && (regIndex == `CFRWP_IDX_PTR_LOW);
   assign hitHigh = aligned && (regIndex == `CFRWP_IDX_PTR_HIGH);
   assign hitStack = aligned && (regIndex == `CFRWP_IDX_STACK);
   assign mapped = hitFlags || hitLow || hitHigh || hitStack;
   assign busWrite = psel && penable && pwrite && pready;
   assign setupRead = psel && !penable;

   // zero wait states; ready holds low only through reset
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pready <= 1'b0;
      end
      else
      begin
         pready <= 1'b1;
      end
   end

   // read data and error are captured in the setup cycle
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else if (setupRead)
      begin
         pslverr <= !mapped;
         if (pwrite || !mapped)
         begin
            prdata <= 32'h0000_0000;
         end
         else if (hitFlags)
         begin
            prdata <= {24'h00_0000, flags};
         end
         else if (hitLow)
         begin
            prdata <= {24'h00_0000, windowPtrLow};
         end
         else if (hitHigh)
         begin
            prdata <= {24'h00_0000, windowPtrHigh};
         end
         else
         begin
            prdata <= {24'h00_0000, stackOverflow, 4'h0, stackDepth};
         end
      end
   end

   // ****************************************
   // arithmetic and flag sources
   // ****************************************
   always_comb
   begin
      aa = fitW(opA, opWord);
      bb = fitW(opB, opWord);
      sum = 17'h0_0000;
      aluRes = aa;
      adj = 8'h00;
      daLow = 1'b0;
      daHigh = 1'b0;
      aluC = cin;
      aluV = 1'b0;
      aluH = flags[`CFRWP_BIT_H];
      aluKind = flags[`CFRWP_BIT_DA];
      updC = 1'b0;
      updZsv = 1'b0;
      updBcd = 1'b0;
      case (opCode)
         OP_ADD, OP_ADC:
         begin
            sum = {1'b0, aa} + {1'b0, bb} + {16'h0000, (opCode == OP_ADC) && cin};
            aluRes = fitW(sum[15:0], opWord);
            aluC = carryOf(sum, opWord);
            aluV = (msbOf(aa, opWord) == msbOf(bb, opWord))
                   && (msbOf(aluRes, opWord) != msbOf(aa, opWord));
            aluH = aa[4] ^ bb[4] ^ sum[4];
            aluKind = 1'b0;
            updC = 1'b1;
            updZsv = 1'b1;
            updBcd = !opWord;
         end
         OP_SUB, OP_SBC, OP_CP:
         begin
            sum = {1'b0, aa} - {1'b0, bb} - {16'h0000, (opCode == OP_SBC) && cin};
            aluRes = fitW(sum[15:0], opWord);
            aluC = carryOf(sum, opWord);
            aluV = (msbOf(aa, opWord) != msbOf(bb, opWord))
                   && (msbOf(aluRes, opWord) != msbOf(aa, opWord));
            aluH = aa[4] ^ bb[4] ^ sum[4];
            aluKind = 1'b1;
            updC = 1'b1;
            updZsv = 1'b1;
            updBcd = !opWord;
         end
         OP_AND, OP_TM:
         begin
            aluRes = aa & bb;
            updZsv = 1'b1;
         end
         OP_OR:
         begin
            aluRes = aa | bb;
            updZsv = 1'b1;
         end
         OP_XOR:
         begin
            aluRes = aa ^ bb;
            updZsv = 1'b1;
         end
         OP_CPL:
         begin
            aluRes = fitW(~aa, opWord);
            updZsv = 1'b1;
         end
         OP_INC, OP_DEC:
         begin
            sum = (opCode == OP_INC) ? {1'b0, aa} + 17'h0_0001 : {1'b0, aa} - 17'h0_0001;
            aluRes = fitW(sum[15:0], opWord);
            aluV = (opCode == OP_INC)
                   ? (!msbOf(aa, opWord) && msbOf(aluRes, opWord))
                   : (msbOf(aa, opWord) && !msbOf(aluRes, opWord));
            updZsv = 1'b1;
         end
         OP_SRA, OP_RRC, OP_ROR:
         begin
            // the bit shifted in at the top depends on the flavour
            if (opCode == OP_SRA)
            begin
               adj = {7'h00, msbOf(aa, opWord)};
            end
            else if (opCode == OP_RRC)
            begin
               adj = {7'h00, cin};
            end
            else
            begin
               adj = {7'h00, aa[0]};
            end
            aluRes = opWord ? {adj[0], aa[15:1]} : {8'h00, adj[0], aa[7:1]};
            aluC = aa[0];
            aluV = msbOf(aa, opWord) ^ msbOf(aluRes, opWord);
            updC = 1'b1;
            updZsv = 1'b1;
         end
         OP_SLA, OP_RLC, OP_ROL:
         begin
            if (opCode == OP_RLC)
            begin
               adj = {7'h00, cin};
            end
            else if (opCode == OP_ROL)
            begin
               adj = {7'h00, msbOf(aa, opWord)};
            end
            aluRes = fitW({aa[14:0], adj[0]}, opWord);
            aluC = msbOf(aa, opWord);
            aluV = msbOf(aa, opWord) ^ msbOf(aluRes, opWord);
            updC = 1'b1;
            updZsv = 1'b1;
         end
         OP_SWAP:
         begin
            aluRes = {8'h00, aa[3:0], aa[7:4]};
            aluC = 1'b0;
            updC = 1'b1;
            updZsv = 1'b1;
         end
         OP_DA:
         begin
            // correction depends on the kind of the previous byte op
            daLow = flags[`CFRWP_BIT_H]
                    || (!flags[`CFRWP_BIT_DA] && (aa[3:0] > 4'h9));
            daHigh = cin || (!flags[`CFRWP_BIT_DA] && (aa[7:0] > 8'h99));
            adj = {daHigh ? 4'h6 : 4'h0, daLow ? 4'h6 : 4'h0};
            aluRes = {8'h00, flags[`CFRWP_BIT_DA] ? aa[7:0] - adj
                                                  : aa[7:0] + adj};
            aluC = daHigh;
            updC = 1'b1;
            updZsv = 1'b1;
         end
         OP_MULDIV:
         begin
            // multiply and divide are computed outside; carry and overflow come with them
            aluRes = fitW(extResult, opWord);
            aluC = extFlags[3];
            aluV = extFlags[0];
            updC = 1'b1;
            updZsv = 1'b1;
         end
         default:
         begin
            aluRes = aa;
         end
      endcase
   end

   // ****************************************
   // status register
   // ****************************************
   assign doPush = opValid && (opCode == OP_IRQ);
   assign doPop = opValid && (opCode == OP_IRET);

   always_comb
   begin
      next_flags = flags;
      if (busWrite && hitFlags)
      begin
         next_flags = pwdata[7:0] & `CFRWP_FLAGS_WMASK;
      end
      if (opValid)
      begin
         // an op overrides only the bits it affects
         if (updC)
         begin
            next_flags[`CFRWP_BIT_C] = aluC;
         end
         if (updZsv)
         begin
            next_flags[`CFRWP_BIT_Z] = (aluRes == 16'h0000);
            next_flags[`CFRWP_BIT_S] = msbOf(aluRes, opWord);
            next_flags[`CFRWP_BIT_V] = aluV;
         end
         if (updBcd)
         begin
            next_flags[`CFRWP_BIT_DA] = aluKind;
            next_flags[`CFRWP_BIT_H] = aluH;
         end
         case (opCode)
            OP_SCF:  next_flags[`CFRWP_BIT_C] = 1'b1;
            OP_RCF:  next_flags[`CFRWP_BIT_C] = 1'b0;
            OP_CCF:  next_flags[`CFRWP_BIT_C] = !cin;
            OP_SDM:  next_flags[`CFRWP_BIT_DP] = 1'b1;
            OP_SPM:  next_flags[`CFRWP_BIT_DP] = 1'b0;
            OP_IRET: next_flags = stackTop;
            default: next_flags = next_flags;
         endcase
      end
      next_flags[`CFRWP_BIT_RSV] = 1'b0;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         flags <= `CFRWP_FLAGS_RESET;
         dataSpace <= 1'b0;
      end
      else
      begin
         flags <= next_flags;
         // set: data pages, clear: code segment for data accesses
         dataSpace <= next_flags[`CFRWP_BIT_DP];
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         resultOut <= 16'h0000;
      end
      else if (opValid && (updC || updZsv))
      begin
         resultOut <= aluRes;
      end
   end

   cfrwp_flag_stack u_stack
   (
      .clk      (clk),
      .rst      (rst),
      .push     (doPush),
      .pop      (doPop),
      .pushData (flags),
      .topData  (stackTop),
      .depth    (stackDepth),
      .overflow (stackOverflow)
   );

   // ****************************************
   // window pointers
   // ****************************************
   always_comb
   begin
      next_ptrLow = windowPtrLow;
      next_ptrHigh = windowPtrHigh;
      if (busWrite && hitLow)
      begin
         next_ptrLow = pwdata[7:0] & `CFRWP_PTR_MASK;
      end
      if (busWrite && hitHigh)
      begin
         next_ptrHigh = pwdata[7:0] & `CFRWP_PTR_MASK;
      end
      if (opValid)
      begin
         case (opCode)
            OP_SRP:
            begin
               next_ptrLow = {opA[4:0], 3'h0};
               next_ptrHigh[`CFRWP_BIT_TWIN] = 1'b0;
            end
            OP_SET_LOWER_WINDOW_OP:
            begin
               next_ptrLow = {opA[4:0], 3'h4};
               next_ptrHigh[`CFRWP_BIT_TWIN] = 1'b1;
            end
            OP_SET_UPPER_WINDOW_OP:
            begin
               next_ptrHigh = {opA[4:0], 3'h4};
               next_ptrLow[`CFRWP_BIT_TWIN] = 1'b1;
            end
            default:
            begin
               next_ptrLow = next_ptrLow;
            end
         endcase
      end
   end

   // the block fields have no defined reset; zero is loaded for determinism
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         windowPtrLow <= `CFRWP_PTR_RESET;
         windowPtrHigh <= `CFRWP_PTR_RESET;
      end
      else
      begin
         windowPtrLow <= next_ptrLow;
         windowPtrHigh <= next_ptrHigh;
      end
   end

   // ****************************************
   // working and direct addressing
   // ****************************************
   cfrwp_win_map u_map
   (
      .ptrLow  (windowPtrLow),
      .ptrHigh (windowPtrHigh),
      .workReg (workReg),
      .regAddr (mapAddr)
   );

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         workAddr <= 8'h00;
         directAllowed <= 1'b0;
      end
      else
      begin
         workAddr <= mapAddr;
         // group D only through working registers or the stack pointers
         directAllowed <= (directAddr < `CFRWP_GROUPD_LO)
                          || (directAddr > `CFRWP_GROUPD_HI);
      end
   end
endmodule

// *** cfrwp_win_map.sv ***
`include "cfrwp_map.svh"
module cfrwp_win_map
(
   input  logic [7:0] ptrLow,
   input  logic [7:0] ptrHigh,
   input  logic [3:0] workReg,
   output logic [7:0] regAddr
);
   always_comb
   begin
      if (ptrLow[`CFRWP_BIT_TWIN])
      begin
         // twin windows: 8 registers each, 32 blocks of eight
         regAddr = workReg[3] ? {ptrHigh[7:3], workReg[2:0]}
                              : {ptrLow[7:3], workReg[2:0]};
      end
      else
      begin
         // low block bit dropped, window starts on an even block
         regAddr = {ptrLow[7:4], workReg};
      end
   end
endmodule
